// ==== design/hpm_buffer.sv ====
// Packet buffer of 16-bit words with per-byte write
`timescale 1ns/1ps
`default_nettype none
`include "hpm_defines.svh"
module hpm_buffer #(
	parameter int unsigned WORDS = `HPM_BUF_WORDS
) (
	input  wire logic                     clk,
	input  wire logic [$clog2(WORDS)-1:0] word_index,
	input  wire logic [1:0]               byte_write,
	input  wire logic [15:0]              write_data,
	output logic      [15:0]              read_data
);
	logic [15:0] store [WORDS];

	always_ff @(posedge clk) begin
		if (byte_write[0]) begin
			store[word_index][7:0] <= write_data[7:0];
		end
		if (byte_write[1]) begin
			store[word_index][15:8] <= write_data[15:8];
		end
		read_data <= store[word_index];
	end
endmodule
`default_nettype wire

// ==== design/hpm_cfg_if.sv ====
// Captured configuration passed between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface hpm_cfg_if;
	import hpm_pkg::*;
	logic      captured;
	logic      serial_sel;
	hpm_mode_t mode;
	logic      wide;
	logic      muxed;
	modport producer (output captured, output serial_sel, output mode, output wide, output muxed);
	modport consumer (input captured, input serial_sel, input mode, input wide, input muxed);
endinterface
`default_nettype wire

// ==== design/hpm_defines.svh ====
// Offsets, field positions and timing counts of the host port block
`ifndef HPM_DEFINES_SVH
`define HPM_DEFINES_SVH

`define HPM_CLK_MHZ          200
`define HPM_STRAP_MIN_US     1
`define HPM_STRAP_MAX_US     10
`define HPM_STRAP_CYCLES     ((`HPM_STRAP_MIN_US * `HPM_CLK_MHZ + `HPM_STRAP_MAX_US * `HPM_CLK_MHZ) / 2)
`define HPM_BUF_WORDS        12288
`define HPM_BUF_END          15'h5FFF
`define HPM_CRYPTO_LO        15'h7800
`define HPM_CRYPTO_HI        15'h7C4F
`define HPM_REG_BASE         15'h7E00
`define HPM_REG_SET_BASE     15'h7F00
`define HPM_REG_CLR_BASE     15'h7F80
`define HPM_REG_BYTES        160
`define HPM_SER_BANK_BYTES   32
`define HPM_SER_UNBANKED     8'h80
`define HPM_PHY_WORDS        32
`define HPM_WORD_ADDR_MAX    14'h3FFF
`define HPM_BYTE_ADDR_MAX    15'h7FFF
`define HPM_STRAP_B0         0
`define HPM_STRAP_B1         1
`define HPM_STRAP_B2         2
`define HPM_STRAP_B3         3
`define HPM_STRAP_B4         4

`endif

// ==== design/hpm_host_port.sv ====
// Host port top: strap capture, parallel bus front end and memory map decode
`timescale 1ns/1ps
`default_nettype none
`include "hpm_defines.svh"
module hpm_host_port
	import hpm_pkg::*;
#(
	parameter int unsigned CAPTURE_CYCLES = `HPM_STRAP_CYCLES,
	parameter bit          LARGE_PACKAGE  = 1'b1,
	parameter int unsigned BUF_WORDS      = `HPM_BUF_WORDS
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        interface_select_strap,
	input  wire logic [4:0]  parallel_mode_strap,
	input  wire logic        chip_select,
	input  wire logic        read_strobe,
	input  wire logic        write_strobe,
	input  wire logic        high_byte_write_strobe,
	input  wire logic        address_latch_strobe,
	input  wire logic        low_byte_lane_select,
	input  wire logic        high_byte_lane_select,
	input  wire logic [14:0] address_pins,
	input  wire logic [15:0] ad_in,
	output logic      [15:0] ad_out,
	output logic      [15:0] ad_oe_n,
	input  wire logic        serial_access,
	input  wire logic        serial_unbanked,
	input  wire logic [1:0]  serial_bank,
	input  wire logic [7:0]  serial_address,
	input  wire logic        pointer_access,
	input  wire logic        pointer_write,
	input  wire logic [14:0] pointer_byte_address,
	input  wire logic [7:0]  pointer_write_data,
	input  wire logic        phy_access,
	input  wire logic [4:0]  phy_word_address,
	output logic             config_valid,
	output logic             serial_selected,
	output logic [3:0]       parallel_mode,
	output logic             cs_pull_up_enable,
	output logic             cs_pull_down_enable,
	output logic             reg_access,
	output logic             reg_write,
	output logic [7:0]       reg_byte_offset,
	output logic [1:0]       reg_op,
	output logic [15:0]      reg_write_data,
	output logic [1:0]       reg_byte_enable,
	output logic             crypto_refused,
	output logic             phy_reg_access,
	output logic [4:0]       phy_reg_index,
	output logic [7:0]       pointer_read_data
);
	localparam int unsigned IW = $clog2(BUF_WORDS);

	hpm_cfg_if cfg ();

	logic        cs_meta, rd_meta, wr_meta, wrh_meta, al_meta, b0_meta, b1_meta;
	logic        cs_s, rd_s, wr_s, wrh_s, al_s, b0_s, b1_s;
	logic [14:0] addr_meta, addr_s;
	logic [15:0] ad_meta, ad_s;
	logic        al_prev;
	logic        wr_prev;
	logic        next_write_active;
	logic [1:0]  lanes_seen;
	logic [14:0] latched_addr;
	logic [14:0] next_byte_addr;
	logic        next_dir_mode;
	logic        next_read_phase;
	logic        next_write_edge;
	logic [1:0]  next_lanes;
	hpm_region_t next_region;
	logic [14:0] buf_byte_addr;
	logic [IW-1:0] buf_index;
	logic [1:0]  buf_we;
	logic [15:0] buf_wdata;
	logic [15:0] buf_rdata;
	logic        ptr_pending;
	logic        ptr_lane;
	logic        hold_read;

	hpm_strap_capture #(
		.CAPTURE_CYCLES (CAPTURE_CYCLES),
		.LARGE_PACKAGE  (LARGE_PACKAGE)
	) u_strap (
		.clk                    (clk),
		.reset                  (reset),
		.interface_select_strap (interface_select_strap),
		.parallel_mode_strap    (parallel_mode_strap),
		.cfg                    (cfg.producer)
	);

	hpm_buffer #(
		.WORDS (BUF_WORDS)
	) u_buffer (
		.clk        (clk),
		.word_index (buf_index),
		.byte_write (buf_we),
		.write_data (buf_wdata),
		.read_data  (buf_rdata)
	);

	// =====================================
	// Pin synchronisers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{cs_meta, rd_meta, wr_meta, wrh_meta, al_meta, b0_meta, b1_meta} <= 7'h00;
			{cs_s, rd_s, wr_s, wrh_s, al_s, b0_s, b1_s} <= 7'h00;
			addr_meta <= 15'h0000;
			addr_s    <= 15'h0000;
			ad_meta   <= 16'h0000;
			ad_s      <= 16'h0000;
		end else begin
			{cs_meta, rd_meta, wr_meta, wrh_meta, al_meta, b0_meta, b1_meta} <=
				{chip_select, read_strobe, write_strobe, high_byte_write_strobe,
				address_latch_strobe, low_byte_lane_select, high_byte_lane_select};
			{cs_s, rd_s, wr_s, wrh_s, al_s, b0_s, b1_s} <=
				{cs_meta, rd_meta, wr_meta, wrh_meta, al_meta, b0_meta, b1_meta};
			addr_meta <= address_pins;
			addr_s    <= addr_meta;
			ad_meta   <= ad_in;
			ad_s      <= ad_meta;
		end
	end

	// =====================================
	// Address latch for multiplexed modes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			al_prev      <= 1'b0;
			latched_addr <= 15'h0000;
		end else begin
			al_prev <= al_s;
			if (cfg.muxed && cs_s && al_prev && !al_s) begin
				latched_addr <= ad_s[14:0];
			end
		end
	end

	// =====================================
	// Parallel strobe and address decode
	always_comb begin
		next_dir_mode = (cfg.mode == HPM_MODE_2) || (cfg.mode == HPM_MODE_4) ||
			(cfg.mode == HPM_MODE_6) || (cfg.mode == HPM_MODE_10);
		// Direction modes: read_strobe is the direction line, write_strobe the enable
		next_read_phase = cfg.captured && !cfg.serial_sel && cs_s &&
			(next_dir_mode ? (rd_s && wr_s) : rd_s);
		if (cfg.mode == HPM_MODE_3 || cfg.mode == HPM_MODE_9) begin
			next_lanes = {wrh_s, wr_s};
		end else if (cfg.mode == HPM_MODE_4 || cfg.mode == HPM_MODE_10) begin
			next_lanes = {b1_s, b0_s};
		end else begin
			next_lanes = 2'b00;
		end
		// Write ends when the last strobe drops; in direction modes a flip to read also ends it
		next_write_active = next_dir_mode ? (wr_s && !rd_s) : (wr_s || next_lanes[1]);
		next_write_edge   = cfg.captured && !cfg.serial_sel && cs_s && wr_prev &&
			!next_write_active;
		if (cfg.muxed) begin
			next_byte_addr = cfg.wide ? {latched_addr[13:0], 1'b0} : latched_addr;
		end else if (cfg.wide) begin
			next_byte_addr = {addr_s[13:0], 1'b0};
		end else begin
			next_byte_addr = addr_s;
		end
		if (next_byte_addr <= `HPM_BUF_END) begin
			next_region = HPM_REGION_BUFFER;
		end else if (next_byte_addr >= `HPM_CRYPTO_LO && next_byte_addr <= `HPM_CRYPTO_HI) begin
			next_region = HPM_REGION_CRYPTO;
		end else if (next_byte_addr >= `HPM_REG_CLR_BASE) begin
			next_region = HPM_REGION_REG_CLR;
		end else if (next_byte_addr >= `HPM_REG_SET_BASE) begin
			next_region = HPM_REGION_REG_SET;
		end else if (next_byte_addr >= `HPM_REG_BASE &&
			next_byte_addr < `HPM_REG_BASE + 15'(`HPM_REG_BYTES)) begin
			next_region = HPM_REGION_REG;
		end else begin
			next_region = HPM_REGION_UNMAPPED;
		end
	end

	// =====================================
	// Buffer port: direct parallel access or pointer window
	always_comb begin
		buf_byte_addr = pointer_access ? pointer_byte_address : next_byte_addr;
		buf_index     = IW'(buf_byte_addr[14:1]);
		buf_we        = 2'b00;
		buf_wdata     = ad_s;
		if (pointer_access) begin
			if (pointer_write) begin
				buf_we    = buf_byte_addr[0] ? 2'b10 : 2'b01;
				buf_wdata = {pointer_write_data, pointer_write_data};
			end
		end else if (next_write_edge && next_region == HPM_REGION_BUFFER) begin
			if (cfg.wide) begin
				buf_we = lanes_seen;
			end else begin
				buf_we    = next_byte_addr[0] ? 2'b10 : 2'b01;
				buf_wdata = {ad_s[7:0], ad_s[7:0]};
			end
		end
	end

	// =====================================
	// Register, crypto and PHY access reporting
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_prev         <= 1'b0;
			lanes_seen      <= 2'b00;
			reg_access      <= 1'b0;
			reg_write       <= 1'b0;
			reg_byte_offset <= 8'h00;
			reg_op          <= 2'b00;
			reg_write_data  <= 16'h0000;
			reg_byte_enable <= 2'b00;
			crypto_refused  <= 1'b0;
		end else begin
			wr_prev         <= next_write_active;
			lanes_seen      <= next_write_active ? (lanes_seen | next_lanes) : 2'b00;
			reg_access      <= 1'b0;
			reg_write       <= 1'b0;
			crypto_refused  <= 1'b0;
			if (cfg.serial_sel && serial_access) begin
				reg_access     <= 1'b1;
				reg_op         <= 2'b00;
				reg_byte_enable <= 2'b01;
				if (serial_unbanked) begin
					reg_byte_offset <= serial_address;
				end else begin
					reg_byte_offset <= {1'b0, serial_bank, serial_address[4:0]};
				end
			end else if (next_write_edge || (next_read_phase && !hold_read)) begin
				if (next_region == HPM_REGION_CRYPTO) begin
					crypto_refused <= 1'b1;
				end else if (next_region == HPM_REGION_REG ||
					next_region == HPM_REGION_REG_SET ||
					next_region == HPM_REGION_REG_CLR) begin
					reg_access      <= 1'b1;
					reg_write       <= next_write_edge;
					reg_byte_offset <= (next_region == HPM_REGION_REG_CLR) ?
						{1'b0, next_byte_addr[6:0]} : next_byte_addr[7:0];
					reg_op          <= (next_region == HPM_REGION_REG_SET) ? 2'b01 :
						(next_region == HPM_REGION_REG_CLR) ? 2'b10 : 2'b00;
					reg_write_data  <= ad_s;
					reg_byte_enable <= cfg.wide ? (next_write_edge ? lanes_seen : next_lanes) :
						(next_byte_addr[0] ? 2'b10 : 2'b01);
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phy_reg_access <= 1'b0;
			phy_reg_index  <= 5'h00;
		end else begin
			phy_reg_access <= phy_access;
			phy_reg_index  <= phy_word_address;
		end
	end

	// =====================================
	// Pointer window read data
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ptr_pending       <= 1'b0;
			ptr_lane          <= 1'b0;
			pointer_read_data <= 8'h00;
		end else begin
			ptr_pending <= pointer_access && !pointer_write;
			ptr_lane    <= pointer_byte_address[0];
			if (ptr_pending) begin
				pointer_read_data <= ptr_lane ? buf_rdata[15:8] : buf_rdata[7:0];
			end
		end
	end

	// =====================================
	// Bus drive: only during a selected parallel read
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hold_read <= 1'b0;
			ad_out    <= 16'h0000;
			ad_oe_n   <= 16'hFFFF;
		end else begin
			hold_read <= next_read_phase;
			if (next_read_phase && !cfg.muxed) begin
				ad_out  <= cfg.wide ? buf_rdata :
					{8'h00, (next_byte_addr[0] ? buf_rdata[15:8] : buf_rdata[7:0])};
				ad_oe_n <= cfg.wide ? 16'h0000 : 16'hFF00;
			end else if (next_read_phase && cfg.muxed && !al_s) begin
				ad_out  <= cfg.wide ? buf_rdata :
					{8'h00, (next_byte_addr[0] ? buf_rdata[15:8] : buf_rdata[7:0])};
				ad_oe_n <= cfg.wide ? 16'h0000 : 16'hFF00;
			end else begin
				ad_oe_n <= 16'hFFFF;
			end
		end
	end

	// =====================================
	// Configuration outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			config_valid        <= 1'b0;
			serial_selected     <= 1'b0;
			parallel_mode       <= 4'h0;
			cs_pull_up_enable   <= 1'b0;
			cs_pull_down_enable <= 1'b0;
		end else begin
			config_valid        <= cfg.captured;
			serial_selected     <= cfg.serial_sel;
			parallel_mode       <= 4'(cfg.mode);
			cs_pull_up_enable   <= cfg.captured && cfg.serial_sel;
			cs_pull_down_enable <= cfg.captured && !cfg.serial_sel;
		end
	end
endmodule
`default_nettype wire

// ==== design/hpm_pkg.sv ====
// Types shared by the host port block
package hpm_pkg;
	typedef enum logic [3:0] {
		HPM_MODE_NONE,
		HPM_MODE_1,
		HPM_MODE_2,
		HPM_MODE_3,
		HPM_MODE_4,
		HPM_MODE_5,
		HPM_MODE_6,
		HPM_MODE_9,
		HPM_MODE_10
	} hpm_mode_t;

	typedef enum logic [2:0] {
		HPM_REGION_BUFFER,
		HPM_REGION_UNMAPPED,
		HPM_REGION_CRYPTO,
		HPM_REGION_REG,
		HPM_REGION_REG_SET,
		HPM_REGION_REG_CLR
	} hpm_region_t;
endpackage

// ==== design/hpm_strap_capture.sv ====
// Power-up strap capture and parallel mode decoder
`timescale 1ns/1ps
`default_nettype none
`include "hpm_defines.svh"
module hpm_strap_capture
	import hpm_pkg::*;
#(
	parameter int unsigned CAPTURE_CYCLES = `HPM_STRAP_CYCLES,
	parameter bit          LARGE_PACKAGE  = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       interface_select_strap,
	input  wire logic [4:0] parallel_mode_strap,
	hpm_cfg_if.producer     cfg
);
	logic       sel_meta;
	logic       sel_sync;
	logic [4:0] cfg_meta;
	logic [4:0] cfg_sync;
	logic [15:0] wait_count;
	hpm_mode_t  next_mode;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sel_meta <= 1'b0;
			sel_sync <= 1'b0;
			cfg_meta <= 5'h00;
			cfg_sync <= 5'h00;
		end else begin
			sel_meta <= interface_select_strap;
			sel_sync <= sel_meta;
			cfg_meta <= parallel_mode_strap;
			cfg_sync <= cfg_meta;
		end
	end

	// =====================================
	// Mode decode
	always_comb begin
		next_mode = HPM_MODE_NONE;
		if (!LARGE_PACKAGE) begin
			next_mode = cfg_sync[`HPM_STRAP_B0] ? HPM_MODE_6 : HPM_MODE_5;
		end else if (!cfg_sync[`HPM_STRAP_B3]) begin
			unique case ({cfg_sync[`HPM_STRAP_B2], cfg_sync[`HPM_STRAP_B4]})
				2'b00: next_mode = HPM_MODE_1;
				2'b01: next_mode = HPM_MODE_2;
				2'b10: next_mode = HPM_MODE_3;
				2'b11: next_mode = HPM_MODE_4;
			endcase
		end else begin
			unique case ({cfg_sync[`HPM_STRAP_B2], cfg_sync[`HPM_STRAP_B1]})
				2'b00: next_mode = HPM_MODE_5;
				2'b01: next_mode = HPM_MODE_6;
				2'b10: next_mode = HPM_MODE_9;
				2'b11: next_mode = HPM_MODE_10;
			endcase
		end
	end

	// =====================================
	// One-shot capture after reset release
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_count     <= 16'h0000;
			cfg.captured   <= 1'b0;
			cfg.serial_sel <= 1'b0;
			cfg.mode       <= HPM_MODE_NONE;
			cfg.wide       <= 1'b0;
			cfg.muxed      <= 1'b0;
		end else if (!cfg.captured) begin
			wait_count <= wait_count + 16'h0001;
			if (wait_count == 16'(CAPTURE_CYCLES - 1)) begin
				cfg.captured   <= 1'b1;
				cfg.serial_sel <= sel_sync;
				cfg.mode       <= sel_sync ? HPM_MODE_NONE : next_mode;
				cfg.wide       <= !sel_sync && (next_mode == HPM_MODE_3 ||
					next_mode == HPM_MODE_4 || next_mode == HPM_MODE_9 ||
					next_mode == HPM_MODE_10);
				cfg.muxed      <= !sel_sync && (next_mode == HPM_MODE_5 ||
					next_mode == HPM_MODE_6 || next_mode == HPM_MODE_9 ||
					next_mode == HPM_MODE_10);
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/hpm_host_model.sv ====
// Host side model driving the parallel bus pins
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model (
	input  wire logic        clk,
	input  wire logic [15:0] ad_out,
	input  wire logic [15:0] ad_oe_n,
	output logic             chip_select,
	output logic             read_strobe,
	output logic             write_strobe,
	output logic             high_byte_write_strobe,
	output logic             address_latch_strobe,
	output logic [14:0]      address_pins,
	output logic [15:0]      ad_in
);
	logic        host_oe = 1'b0;
	logic [15:0] host_val = 16'h0000;
	logic [15:0] last_lvl = 16'h0000;
	// Released lines toggle so a stale value never reads as valid
	assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & (host_oe ? host_val : ~last_lvl));
	always @(posedge clk) last_lvl <= ad_in;
	initial begin
		chip_select = 1'b0;
		read_strobe = 1'b0;
		write_strobe = 1'b0;
		high_byte_write_strobe = 1'b0;
		address_latch_strobe = 1'b0;
		address_pins = 15'h0000;
	end
	// One read or write cycle; lanes[0] low strobe, lanes[1] high strobe
	task automatic access(input logic rd, input logic mux, input logic [14:0] a,
		input logic [15:0] d, input logic [1:0] lanes, output logic [15:0] rdata);
		@(posedge clk);
		#1;
		chip_select = 1'b1;
		if (mux) begin
			host_oe = 1'b1;
			host_val = {1'b0, a};
			address_latch_strobe = 1'b1;
			repeat (4) @(posedge clk);
			#1;
			address_latch_strobe = 1'b0;
			repeat (3) @(posedge clk);
			#1;
		end else begin
			address_pins = a;
		end
		if (rd) begin
			host_oe = 1'b0;
			read_strobe = 1'b1;
			repeat (8) @(posedge clk);
			rdata = ad_in;
			#1;
			read_strobe = 1'b0;
		end else begin
			host_oe = 1'b1;
			host_val = d;
			write_strobe = lanes[0];
			high_byte_write_strobe = lanes[1];
			repeat (4) @(posedge clk);
			#1;
			write_strobe = 1'b0;
			high_byte_write_strobe = 1'b0;
			repeat (4) @(posedge clk);
			#1;
		end
		chip_select = 1'b0;
		host_oe = 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ==== dv/hpm_host_port_asserts.sv ====
// Concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none
module hpm_host_port_asserts #(
	parameter int unsigned CAPTURE_CYCLES = 4
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        chip_select,
	input wire logic        serial_access,
	input wire logic        serial_unbanked,
	input wire logic [1:0]  serial_bank,
	input wire logic [7:0]  serial_address,
	input wire logic        phy_access,
	input wire logic [4:0]  phy_word_address,
	input wire logic [15:0] ad_oe_n,
	input wire logic        config_valid,
	input wire logic        serial_selected,
	input wire logic [3:0]  parallel_mode,
	input wire logic        cs_pull_up_enable,
	input wire logic        cs_pull_down_enable,
	input wire logic        reg_access,
	input wire logic [7:0]  reg_byte_offset,
	input wire logic        crypto_refused,
	input wire logic        phy_reg_access,
	input wire logic [4:0]  phy_reg_index
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic [15:0] since_rst;
	logic [7:0]  banked_off;
	assign banked_off = {1'b0, serial_bank, serial_address[4:0]};
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			since_rst <= 16'h0000;
		end else if (since_rst != 16'hFFFF) begin
			since_rst <= since_rst + 16'h0001;
		end
	end
	// ==========================================
	// Properties
	sequence s_ser(logic unb);
		config_valid && serial_selected && serial_access && serial_unbanked == unb;
	endsequence
	property p_cfg_time;
		$rose(config_valid) |-> since_rst >= 16'(CAPTURE_CYCLES) && since_rst <= 16'(CAPTURE_CYCLES + 2);
	endproperty
	property p_cfg_late;
		since_rst >= 16'(CAPTURE_CYCLES + 4) |-> config_valid;
	endproperty
	property p_cfg_hold;
		config_valid && $past(config_valid) |-> $stable(serial_selected) && $stable(parallel_mode);
	endproperty
	property p_mode_legal;
		config_valid && !serial_selected |-> parallel_mode >= 4'h1 && parallel_mode <= 4'h8;
	endproperty
	property p_pull;
		config_valid |-> cs_pull_up_enable == serial_selected && cs_pull_down_enable == !serial_selected;
	endproperty
	property p_idle_in;
		!chip_select [*4] |=> ad_oe_n == 16'hFFFF;
	endproperty
	property p_serial_float;
		config_valid && serial_selected |-> ad_oe_n == 16'hFFFF;
	endproperty
	property p_narrow_top;
		config_valid && (parallel_mode == 4'h1 || parallel_mode == 4'h2) |-> ad_oe_n[15:8] == 8'hFF;
	endproperty
	property p_crypto_excl;
		crypto_refused |-> !reg_access;
	endproperty
	property p_phy_echo;
		phy_access |=> phy_reg_access && phy_reg_index == $past(phy_word_address);
	endproperty
	property p_banked;
		s_ser(1'b0) |=> reg_access && reg_byte_offset == $past(banked_off);
	endproperty
	property p_unbanked;
		s_ser(1'b1) |=> reg_access && reg_byte_offset == $past(serial_address);
	endproperty
	a_cfg_time: assert property (p_cfg_time) else $error("config late or early");
	a_cfg_late: assert property (p_cfg_late) else $error("config never valid");
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");
	a_mode_legal: assert property (p_mode_legal) else $error("bad parallel mode");
	a_pull: assert property (p_pull) else $error("chip select pulls wrong");
	a_idle_in: assert property (p_idle_in) else $error("bus driven while deselected");
	a_serial_float: assert property (p_serial_float) else $error("bus driven in serial");
	a_narrow_top: assert property (p_narrow_top) else $error("unused lines driven");
	a_crypto_excl: assert property (p_crypto_excl) else $error("crypto reached");
	a_phy_echo: assert property (p_phy_echo) else $error("phy access lost");
	a_banked: assert property (p_banked) else $error("banked offset wrong");
	a_unbanked: assert property (p_unbanked) else $error("unbanked offset wrong");
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Testbench for the host port block
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
	logic clk = 1'b0, reset = 1'b1, interface_select_strap = 1'b0;
	logic [4:0] parallel_mode_strap = 5'h00;
	logic serial_access = 1'b0, serial_unbanked = 1'b0, pointer_access = 1'b0;
	logic pointer_write = 1'b0, phy_access = 1'b0;
	logic [1:0] serial_bank = 2'h0;
	logic [7:0] serial_address = 8'h00, pointer_write_data = 8'h00, pdata;
	logic [14:0] pointer_byte_address = 15'h0000, address_pins;
	logic [4:0] phy_word_address = 5'h00, phy_reg_index, seen_op;
	logic chip_select, read_strobe, write_strobe, high_byte_write_strobe, address_latch_strobe;
	logic [15:0] ad_in, ad_out, ad_oe_n, reg_write_data, rdata, seen_data;
	logic config_valid, serial_selected, cs_pull_up_enable, cs_pull_down_enable, reg_access;
	logic reg_write, crypto_refused, phy_reg_access, seen_reg, seen_cry;
	logic [3:0] parallel_mode;
	logic [7:0] reg_byte_offset, pointer_read_data, seen_off;
	logic [1:0] reg_op, reg_byte_enable;
	int err_count = 0, checked = 0, i;
	logic [5:0] strap_tab [9] = '{6'h20, 6'h02, 6'h11, 6'h06, 6'h14, 6'h18, 6'h0A, 6'h1C, 6'h0E};
	logic [14:0] reg_addr [3] = '{15'h7E03, 15'h7F05, 15'h7F86};
	logic [14:0] cry_addr [3] = '{15'h7800, 15'h7C4F, 15'h7C50};
	always #2.5 clk = ~clk;
	hpm_host_model host (.*);
	hpm_host_port #(.CAPTURE_CYCLES(4)) DUT (.low_byte_lane_select(1'b0),
		.high_byte_lane_select(1'b0), .*);
	// Catch the one-cycle access reports
	always @(posedge clk) begin
		if (reg_access === 1'b1) begin
			seen_reg = 1'b1;
			seen_off = reg_byte_offset;
			seen_op = {reg_write, reg_byte_enable, reg_op};
			seen_data = reg_write_data;
		end
		if (crypto_refused === 1'b1) seen_cry = 1'b1;
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic start(input logic sel, input logic [4:0] strap);
		@(posedge clk);
		#1;
		reset = 1'b1;
		interface_select_strap = sel;
		parallel_mode_strap = strap;
		repeat (3) @(posedge clk);
		#1;
		reset = 1'b0;
		for (int k = 0; k < 40 && config_valid !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (config_valid !== 1'b1) begin
			err_count++;
			report_and_stop();
		end
	endtask
	task automatic bus(input logic rd, input logic mux, input logic [14:0] a,
		input logic [15:0] d, input logic [1:0] ln);
		seen_reg = 1'b0;
		seen_cry = 1'b0;
		host.access(rd, mux, a, d, ln, rdata);
	endtask
	task automatic ptr(input logic wr, input logic [14:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		pointer_access = 1'b1;
		pointer_write = wr;
		pointer_byte_address = a;
		pointer_write_data = d;
		@(posedge clk);
		#1;
		pointer_access = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		pdata = pointer_read_data;
	endtask
	task automatic ser(input logic unb, input logic [1:0] bank, input logic [7:0] a);
		seen_reg = 1'b0;
		@(posedge clk);
		#1;
		serial_access = 1'b1;
		serial_unbanked = unb;
		serial_bank = bank;
		serial_address = a;
		@(posedge clk);
		#1;
		serial_access = 1'b0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		#40000;
		err_count++;
		report_and_stop();
	end
	initial begin
		for (i = 0; i < 9; i++) begin
			start(strap_tab[i][5], strap_tab[i][4:0]);
			`CHECK_EQ(serial_selected, strap_tab[i][5])
			`CHECK_EQ(parallel_mode, 4'(i))
			`CHECK_EQ(cs_pull_down_enable, ~strap_tab[i][5])
			interface_select_strap = ~interface_select_strap;
			parallel_mode_strap = ~parallel_mode_strap;
			repeat (8) @(posedge clk);
			#1;
			`CHECK_EQ(parallel_mode, 4'(i))
		end
		$display("strap decode test done");
		start(1'b0, 5'h02);
		for (i = 0; i < 3; i++) begin
			bus(1'b0, 1'b0, reg_addr[i], 16'h005A, 2'b01);
			`CHECK_EQ(seen_off, {1'b0, reg_addr[i][6:0]})
			`CHECK_EQ(seen_op, {1'b1, reg_addr[i][0], !reg_addr[i][0], 2'(i)})
			`CHECK_EQ(seen_data[7:0], 8'h5A)
			bus(1'b0, 1'b0, cry_addr[i], 16'h00C3, 2'b01);
			`CHECK_EQ(seen_cry, (i < 2))
			`CHECK_EQ(seen_reg, 1'b0)
		end
		bus(1'b0, 1'b0, 15'h0013, 16'h00A7, 2'b01);
		bus(1'b1, 1'b0, 15'h0013, 16'h0000, 2'b00);
		`CHECK_EQ(rdata[7:0], 8'hA7)
		ptr(1'b0, 15'h0013, 8'h00);
		`CHECK_EQ(pdata, 8'hA7)
		ptr(1'b1, 15'h5FFF, 8'h3C);
		bus(1'b1, 1'b0, 15'h5FFF, 16'h0000, 2'b00);
		`CHECK_EQ(rdata[7:0], 8'h3C)
		$display("byte mode test done");
		start(1'b0, 5'h06);
		bus(1'b0, 1'b0, 15'h0008, 16'h1234, 2'b11);
		bus(1'b0, 1'b0, 15'h0008, 16'hBB00, 2'b10);
		ptr(1'b0, 15'h0010, 8'h00);
		`CHECK_EQ(pdata, 8'h34)
		ptr(1'b0, 15'h0011, 8'h00);
		`CHECK_EQ(pdata, 8'hBB)
		bus(1'b1, 1'b0, 15'h0008, 16'h0000, 2'b00);
		`CHECK_EQ(rdata, 16'hBB34)
		$display("word mode test done");
		start(1'b0, 5'h18);
		bus(1'b0, 1'b1, 15'h7E02, 16'h005A, 2'b01);
		`CHECK_EQ(seen_off, 8'h02)
		ptr(1'b1, 15'h0040, 8'h66);
		bus(1'b1, 1'b1, 15'h0040, 16'h0000, 2'b00);
		`CHECK_EQ(rdata[7:0], 8'h66)
		$display("multiplexed mode test done");
		start(1'b1, 5'h00);
		ser(1'b0, 2'h2, 8'h05);
		`CHECK_EQ(seen_off, 8'h45)
		ser(1'b0, 2'h3, 8'h1F);
		`CHECK_EQ(seen_off, 8'h7F)
		ser(1'b1, 2'h0, 8'h85);
		`CHECK_EQ(seen_off, 8'h85)
		ptr(1'b1, 15'h0100, 8'h9E);
		ptr(1'b0, 15'h0100, 8'h00);
		`CHECK_EQ(pdata, 8'h9E)
		@(posedge clk);
		#1;
		phy_access = 1'b1;
		phy_word_address = 5'h1F;
		@(posedge clk);
		#1;
		phy_access = 1'b0;
		`CHECK_EQ(phy_reg_index, 5'h1F)
		`CHECK_EQ(phy_reg_access, 1'b1)
		$display("serial mode test done");
		report_and_stop();
	end
endmodule
bind hpm_host_port hpm_host_port_asserts #(.CAPTURE_CYCLES(CAPTURE_CYCLES)) u_chk (
	.clk(clk), .reset(reset), .chip_select(chip_select), .serial_access(serial_access),
	.serial_unbanked(serial_unbanked), .serial_bank(serial_bank),
	.serial_address(serial_address), .phy_access(phy_access),
	.phy_word_address(phy_word_address), .ad_oe_n(ad_oe_n), .config_valid(config_valid),
	.serial_selected(serial_selected), .parallel_mode(parallel_mode),
	.cs_pull_up_enable(cs_pull_up_enable), .cs_pull_down_enable(cs_pull_down_enable),
	.reg_access(reg_access), .reg_byte_offset(reg_byte_offset),
	.crypto_refused(crypto_refused), .phy_reg_access(phy_reg_access),
	.phy_reg_index(phy_reg_index));
`default_nettype wire
